// ---- design/cmp_ctrl_pkg.sv ----
/*
  Constants, register layout and carrier types for the analog comparator
  control block. Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
// Functional notes
// - bit 7 enables the comparator; when clear it idles in low power.
// - bit 6 picks plus pin (0) or bandgap (1); minus pin inverting.
// - edge field 00 falling, 01 rising, 10 falling, 11 either edge.
// - event flag sets on selected edge, cleared by writing 1 or by deep stop.
// - interrupt request is flag AND enable; enable cleared by writing 0.
// - readback bit shows comparator output, zero while module disabled.
// - comparator output high when non-inverting input exceeds inverting input.
// - wait mode: enabled comparator keeps running, interrupt may wake CPU.
// - stop mode: clocks halted, low power, no compare events detected.
// - deep stop recovery leaves the module in its reset state.
// - light stop recovery keeps register contents and resumes operation.
// - background debug mode does not disturb comparator operation.
package cmp_ctrl_pkg;
  localparam logic [3:0] CSC_OFFSET = 4'h0;
  localparam logic [3:0] MODE_OFFSET = 4'h4;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_REF_SEL = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQ_EN = 4;
  localparam int BIT_READBACK = 3;
  localparam logic [7:0] CSC_RESET = 8'h00;
  localparam logic [1:0] EDGE_FALL0 = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL1 = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_WAIT,
    PWR_STOP_LIGHT,
    PWR_STOP_DEEP
  } power_mode_e;

  typedef struct packed {
    logic enable;
    logic ref_sel;
    logic irq_en;
    logic [1:0] edge_sel;
  } csc_s;
endpackage

// ---- design/analog_comparator_control.sv ----
/*
  Control and status logic around an on-chip analog comparator.
  Assumes an Avalon-MM master on sys_clk and an asynchronous comparator
  output; the chip power controller drives power_mode and debug_active.
*/
`timescale 1ns/100ps
module analog_comparator_control (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] power_mode,
  input wire logic debug_active,
  input wire logic cmp_raw_out,
  output logic comparator_power_on,
  output logic reference_select,
  output logic compare_irq
);
  // ************
  // bus handshake
  // ************
  logic busy;
  logic take;
  logic wr_take;
  logic rd_take;
  logic stop_any;
  logic deep_stop;

  assign stop_any = (power_mode == 2'(cmp_ctrl_pkg::PWR_STOP_LIGHT)) ||
                    (power_mode == 2'(cmp_ctrl_pkg::PWR_STOP_DEEP));
  assign deep_stop = (power_mode == 2'(cmp_ctrl_pkg::PWR_STOP_DEEP));
  // one wait cycle per access, answer on second edge
  assign take = (avs_read || avs_write) && !busy;
  assign wr_take = avs_write && busy;
  assign rd_take = avs_read && busy;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else if (busy) begin
      busy <= 1'b0;
    end else begin
      busy <= take;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !take;
    end
  end

  a_wait_short: assert property (@(posedge sys_clk) disable iff (!resetn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_next: assert property (@(posedge sys_clk) disable iff (!resetn)
    take |=> !avs_waitrequest)
    else $error("answer late");
  a_idle_waits: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!avs_read && !avs_write) |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_busy_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
    busy |=> !busy)
    else $error("access stuck busy");
  a_take_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
    take |=> busy)
    else $error("access not started");

  // ************
  // control fields
  // ************
  cmp_ctrl_pkg::csc_s ctl;
  logic csc_wr;
  logic flag_clr;
  assign csc_wr = wr_take && (avs_address == cmp_ctrl_pkg::CSC_OFFSET);
  assign flag_clr = csc_wr && avs_writedata[cmp_ctrl_pkg::BIT_FLAG];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl <= '0;
    end else if (deep_stop) begin
      ctl <= '0;
    end else if (csc_wr) begin
      ctl.enable <= avs_writedata[cmp_ctrl_pkg::BIT_ENABLE];
      ctl.ref_sel <= avs_writedata[cmp_ctrl_pkg::BIT_REF_SEL];
      ctl.irq_en <= avs_writedata[cmp_ctrl_pkg::BIT_IRQ_EN];
      ctl.edge_sel <= avs_writedata[1:0];
    end
  end

  a_enable_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
    (csc_wr && !deep_stop) |=> ctl.enable == $past(avs_writedata[cmp_ctrl_pkg::BIT_ENABLE]))
    else $error("enable write lost");
  a_ref_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
    (csc_wr && !deep_stop) |=> ctl.ref_sel == $past(avs_writedata[cmp_ctrl_pkg::BIT_REF_SEL]))
    else $error("reference write lost");
  a_irq_en_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
    (csc_wr && !deep_stop) |=> ctl.irq_en == $past(avs_writedata[cmp_ctrl_pkg::BIT_IRQ_EN]))
    else $error("irq enable write lost");
  a_edge_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
    (csc_wr && !deep_stop) |=> ctl.edge_sel == $past(avs_writedata[1:0]))
    else $error("edge select write lost");
  a_ctl_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!csc_wr && !deep_stop) |=> $stable(ctl))
    else $error("control changed without write");

  // ************
  // comparator power and reference
  // ************
  logic active;
  // wait and debug leave it running; light stop keeps state
  assign active = ctl.enable && !stop_any;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      comparator_power_on <= 1'b0;
      reference_select <= 1'b0;
    end else begin
      comparator_power_on <= active;
      reference_select <= ctl.ref_sel;
    end
  end

  a_stop_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    stop_any |=> !comparator_power_on)
    else $error("powered in stop");
  a_ref_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
    reference_select == $past(ctl.ref_sel))
    else $error("reference pin mismatch");
  a_power_run: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctl.enable && !stop_any) |=> comparator_power_on)
    else $error("not powered while enabled");
  a_power_exact: assert property (@(posedge sys_clk) disable iff (!resetn)
    comparator_power_on == $past(active))
    else $error("power pin mismatch");

  // ************
  // synchroniser and edge detect
  // ************
  logic sync_a;
  logic sync_b;
  logic cmp_q;
  logic cmp_q_valid;
  logic rise;
  logic fall;
  logic hit;

  // polarity set by the analog cell; raw high means plus above minus
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= cmp_raw_out;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_q <= 1'b0;
      cmp_q_valid <= 1'b0;
    end else begin
      cmp_q <= active ? sync_b : 1'b0;
      cmp_q_valid <= active && comparator_power_on;
    end
  end

  assign rise = cmp_q_valid && active && sync_b && !cmp_q;
  assign fall = cmp_q_valid && active && !sync_b && cmp_q;

  always_comb begin
    case (ctl.edge_sel)
      cmp_ctrl_pkg::EDGE_FALL0: hit = fall;
      cmp_ctrl_pkg::EDGE_RISE: hit = rise;
      cmp_ctrl_pkg::EDGE_FALL1: hit = fall;
      cmp_ctrl_pkg::EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
  end

  a_edge_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(rise && fall))
    else $error("rise and fall together");
  a_no_edge_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    !active |-> !(rise || fall))
    else $error("edge while inactive");
  a_fall0_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fall && ctl.edge_sel == cmp_ctrl_pkg::EDGE_FALL0 && !deep_stop) |=> flag)
    else $error("fall missed in mode 0");
  a_fall1_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fall && ctl.edge_sel == cmp_ctrl_pkg::EDGE_FALL1 && !deep_stop) |=> flag)
    else $error("fall missed in mode 2");
  a_both_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((rise || fall) && ctl.edge_sel == cmp_ctrl_pkg::EDGE_BOTH && !deep_stop) |=> flag)
    else $error("edge missed in mode 3");
  a_rise_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!flag && rise && (ctl.edge_sel == cmp_ctrl_pkg::EDGE_FALL0 || ctl.edge_sel == cmp_ctrl_pkg::EDGE_FALL1)) |=> !flag)
    else $error("rise set flag");
  a_readback_live: assert property (@(posedge sys_clk) disable iff (!resetn)
    active |=> cmp_q == $past(sync_b))
    else $error("readback stale");
  a_readback_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    stop_any |=> !cmp_q)
    else $error("readback set in stop");
  a_sync_chain: assert property (@(posedge sys_clk) disable iff (!resetn)
    sync_b == $past(sync_a))
    else $error("second stage mismatch");

  // ************
  // event flag and interrupt
  // ************
  logic flag;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (deep_stop) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (flag_clr) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      compare_irq <= 1'b0;
    end else begin
      compare_irq <= flag && ctl.irq_en;
    end
  end

  a_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hit && flag_clr && !deep_stop) |=> flag)
    else $error("clear beat set");
  a_clear_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
    (flag_clr && !hit && !deep_stop) |=> !flag)
    else $error("flag not cleared");
  a_no_set_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!flag && !hit) |=> !flag)
    else $error("flag set without event");
  a_irq_off_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    !flag |=> !compare_irq)
    else $error("irq without flag");
  a_irq_off_en: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctl.irq_en |=> !compare_irq)
    else $error("irq while masked");

  // ************
  // read data
  // ************
  logic [7:0] csc_view;
  assign csc_view = {ctl.enable, ctl.ref_sel, flag, ctl.irq_en, cmp_q, 1'b0, ctl.edge_sel};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (take && avs_read) begin
      case (avs_address)
        cmp_ctrl_pkg::CSC_OFFSET: avs_readdata <= {24'h00_0000, csc_view};
        cmp_ctrl_pkg::MODE_OFFSET: avs_readdata <= {30'h0000_0000, power_mode};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  a_read_csc: assert property (@(posedge sys_clk) disable iff (!resetn)
    (take && avs_read && avs_address == cmp_ctrl_pkg::CSC_OFFSET) |=> avs_readdata == {24'h00_0000, $past(csc_view)})
    else $error("status read mismatch");
  a_read_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
    (take && avs_read && avs_address == cmp_ctrl_pkg::MODE_OFFSET) |=> avs_readdata == {30'h0000_0000, $past(power_mode)})
    else $error("mode read mismatch");
  a_read_upper: assert property (@(posedge sys_clk) disable iff (!resetn)
    avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_read_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(take && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed");

  // ************
  // checks
  // ************
  a_irq_follows_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    (flag && ctl.irq_en) |=> compare_irq) else $error("irq missing");
  a_irq_needs_both: assert property (@(posedge sys_clk) disable iff (!resetn)
    compare_irq |-> $past(flag) && $past(ctl.irq_en)) else $error("irq without cause");
  a_readback_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctl.enable |=> !cmp_q) else $error("readback not zero");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    (flag && !flag_clr && !deep_stop) |=> flag) else $error("flag lost");
  a_stop_no_event: assert property (@(posedge sys_clk) disable iff (!resetn)
    (stop_any && !flag) |=> !flag) else $error("event in stop");
  a_power_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctl.enable |=> !comparator_power_on) else $error("powered while off");
  a_rise_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rise && ctl.edge_sel == cmp_ctrl_pkg::EDGE_RISE && !deep_stop) |=> flag) else $error("rise missed");
  a_fall_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!flag && fall && ctl.edge_sel == cmp_ctrl_pkg::EDGE_RISE && !flag_clr) |=> !flag) else $error("fall set flag");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active && $past(active) && $past(active, 2)) |-> sync_b == $past(cmp_raw_out, 2)) else $error("sync depth");
  a_deep_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    deep_stop |=> (ctl == '0 && !flag)) else $error("deep stop kept state");
  a_light_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    (power_mode == 2'(cmp_ctrl_pkg::PWR_STOP_LIGHT) && !csc_wr) |=> $stable(ctl)) else $error("light stop lost");
  a_wait_runs: assert property (@(posedge sys_clk) disable iff (!resetn)
    (power_mode == 2'(cmp_ctrl_pkg::PWR_WAIT) && ctl.enable) |=> comparator_power_on) else $error("wait stopped");
  a_debug_runs: assert property (@(posedge sys_clk) disable iff (!resetn)
    (debug_active && ctl.enable && !stop_any) |=> comparator_power_on) else $error("debug stopped");
endmodule

// ---- testbench/analog_comparator_control_tb.sv ----
/*
  Self-checking bench for the comparator control block.
  Assumes the slave answers one edge after taking a request; a watchdog ends a hang.
*/
`timescale 1ns/100ps
module analog_comparator_control_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] power_mode = 2'h0;
  logic debug_active = 1'b0;
  logic cmp_raw_out = 1'b0;
  logic comparator_power_on, reference_select, compare_irq;
  logic [31:0] rd;
  int n_fail = 0;
  int n_compared = 0;
  analog_comparator_control i_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_mode(power_mode), .debug_active(debug_active),
    .cmp_raw_out(cmp_raw_out), .comparator_power_on(comparator_power_on),
    .reference_select(reference_select), .compare_irq(compare_irq));
  always #20 sys_clk = ~sys_clk;
  // ****************
  // shared tasks
  // ****************
  task check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task check_pin(input logic got, input logic exp, input string what);
    check_reg({31'h0, got}, {31'h0, exp}, what);
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      k++;
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check_reg(k, 32'h0000_0001, "bus answer");
  endtask
  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    check_reg(rd, {24'h0, exp}, "register read");
  endtask
  task raw(input logic v);
    @(posedge sys_clk);
    cmp_raw_out <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h8, 8'h00);
    $display("test reset done");
  endtask
  task t_enable;
    raw(1'b1);
    rd_chk(4'h0, 8'h00);
    bus(1'b1, 4'h0, 32'hC0);
    repeat (4) @(posedge sys_clk);
    check_pin(comparator_power_on, 1'b1, "power on");
    check_pin(reference_select, 1'b1, "bandgap");
    rd_chk(4'h0, 8'hC8);
    raw(1'b0);
    rd_chk(4'h0, 8'hE0);
    bus(1'b1, 4'h0, 32'hE0);
    rd_chk(4'h0, 8'hC0);
    $display("test enable done");
  endtask
  task t_modes;
    logic [7:0] m;
    for (m = 0; m < 4; m++) begin
      bus(1'b1, 4'h0, {24'h0, 8'hA0 | m});
      raw(1'b1);
      rd_chk(4'h0, 8'h88 | m | ((m == 1 || m == 3) ? 8'h20 : 8'h00));
      bus(1'b1, 4'h0, {24'h0, 8'hA0 | m});
      raw(1'b0);
      bus(1'b1, 4'h0, {24'h0, 8'h80 | m});
      rd_chk(4'h0, 8'h80 | m | ((m != 1) ? 8'h20 : 8'h00));
    end
    $display("test modes done");
  endtask
  task t_irq;
    bus(1'b1, 4'h0, 32'hB0);
    power_mode <= 2'h1;
    debug_active <= 1'b1;
    raw(1'b1);
    check_pin(compare_irq, 1'b0, "irq idle");
    raw(1'b0);
    check_pin(compare_irq, 1'b1, "irq in wait");
    rd_chk(4'h4, 8'h01);
    bus(1'b1, 4'h0, 32'h80);
    repeat (3) @(posedge sys_clk);
    check_pin(compare_irq, 1'b0, "irq masked");
    bus(1'b1, 4'h0, 32'h90);
    repeat (3) @(posedge sys_clk);
    check_pin(compare_irq, 1'b1, "irq unmasked");
    bus(1'b1, 4'h0, 32'hB0);
    repeat (3) @(posedge sys_clk);
    check_pin(compare_irq, 1'b0, "irq flag cleared");
    power_mode <= 2'h0;
    debug_active <= 1'b0;
    $display("test irq done");
  endtask
  task t_stop;
    bus(1'b1, 4'h0, 32'hF1);
    power_mode <= 2'h2;
    raw(1'b1);
    check_pin(comparator_power_on, 1'b0, "off in stop");
    raw(1'b0);
    power_mode <= 2'h0;
    repeat (4) @(posedge sys_clk);
    rd_chk(4'h0, 8'hD1);
    check_pin(comparator_power_on, 1'b1, "resumed");
    power_mode <= 2'h3;
    repeat (4) @(posedge sys_clk);
    power_mode <= 2'h0;
    repeat (4) @(posedge sys_clk);
    rd_chk(4'h0, 8'h00);
    check_pin(reference_select, 1'b0, "ref after deep stop");
    $display("test stop done");
  endtask
  // ****************
  // verdict and sequence
  // ****************
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_enable;
    t_modes;
    t_irq;
    t_stop;
    give_verdict;
  end
endmodule
